// file: logic/ctim_regs.svh
// Timing counts, field positions and reset values for the instruction timing sequencer
`ifndef CTIM_REGS_SVH
`define CTIM_REGS_SVH

`define CTIM_RST_PC          16'h0000
`define CTIM_RST_BYTE        8'h00
`define CTIM_DIR_SFR_BIT     7
`define CTIM_PTR_SEL_BIT     0
`define CTIM_CYC_ONE         4'h1
`define CTIM_CYC_TWO         4'h2
`define CTIM_CYC_THREE       4'h3
`define CTIM_CYC_MUL         4'h4
`define CTIM_CYC_DIV         4'h8
`define CTIM_CYC_CODE_PC     4'h3
`define CTIM_CYC_CODE_DP_MIN 4'h4
`define CTIM_CYC_CODE_DP_MAX 4'h7
`define CTIM_CYC_EXT_DATA    4'h3
`define CTIM_LEN_ONE         2'h1
`define CTIM_LEN_TWO         2'h2
`define CTIM_LEN_THREE       2'h3

`endif

// file: logic/ctim_pkg.sv
// Types shared by the instruction timing sequencer and its decoder
package ctim_pkg;

  typedef enum logic [1:0] {
    CTIM_ST_OPCODE  = 2'b00,
    CTIM_ST_OPERAND = 2'b01,
    CTIM_ST_STALL   = 2'b11
  } ctim_state_e;

  typedef enum logic [2:0] {
    CTIM_OPR_NONE = 3'h0,
    CTIM_OPR_REG  = 3'h1,
    CTIM_OPR_IND  = 3'h2,
    CTIM_OPR_DIR  = 3'h3,
    CTIM_OPR_IMM  = 3'h4
  } ctim_opr_e;

  typedef struct packed {
    logic [1:0] len;
    logic [3:0] cyc;
    ctim_opr_e  opr;
    logic       code_dp;
    logic       beyond;
  } ctim_dec_s;

endpackage

// file: logic/ctim_dec_if.sv
// Opcode to timing lookup carrier between sequencer and decoder
interface ctim_dec_if;
  logic [7:0]         opcode;
  ctim_pkg::ctim_dec_s info;
  modport dec (input opcode, output info);
  modport seq (output opcode, input info);
endinterface

// file: logic/ctim_decode.sv
// Opcode decoder giving byte count, clock count and operand class
`include "ctim_regs.svh"

module ctim_decode (
  ctim_dec_if.dec dbus
);

  function automatic ctim_pkg::ctim_dec_s mk(
    input logic [1:0] len,
    input logic [3:0] cyc,
    input logic       beyond
  );
    ctim_pkg::ctim_dec_s r;
    r.len     = len;
    r.cyc     = cyc;
    r.opr     = ctim_pkg::CTIM_OPR_NONE;
    r.code_dp = 1'b0;
    r.beyond  = beyond;
    return r;
  endfunction

  // Branch and bit opcodes report length and their shortest time only
  function automatic ctim_pkg::ctim_dec_s lookup(input logic [7:0] op);
    ctim_pkg::ctim_dec_s r;
    logic [3:0]          hi;
    logic [3:0]          lo;
    hi = op[7:4];
    lo = op[3:0];
    r  = mk(`CTIM_LEN_ONE, `CTIM_CYC_ONE, 1'b0);
    if (lo == 4'h1) begin
      r = mk(`CTIM_LEN_TWO, `CTIM_CYC_TWO, 1'b1);
    end else if (lo == 4'h0) begin
      case (hi)
        4'h0:                      r = mk(`CTIM_LEN_ONE, `CTIM_CYC_ONE, 1'b0);
        4'h1, 4'h2, 4'h3:          r = mk(`CTIM_LEN_THREE, `CTIM_CYC_THREE, 1'b1);
        4'h9:                      r = mk(`CTIM_LEN_THREE, `CTIM_CYC_THREE, 1'b0);
        4'hC, 4'hD:                r = mk(`CTIM_LEN_TWO, `CTIM_CYC_TWO, 1'b0);
        4'hE, 4'hF:                r = mk(`CTIM_LEN_ONE, `CTIM_CYC_EXT_DATA, 1'b0);
        default:                   r = mk(`CTIM_LEN_TWO, `CTIM_CYC_TWO, 1'b1);
      endcase
    end else if (lo == 4'h2) begin
      case (hi)
        4'h0, 4'h1:                r = mk(`CTIM_LEN_THREE, `CTIM_CYC_THREE, 1'b1);
        4'h2, 4'h3:                r = mk(`CTIM_LEN_ONE, `CTIM_CYC_ONE, 1'b1);
        4'h4, 4'h5, 4'h6:          r = mk(`CTIM_LEN_TWO, `CTIM_CYC_TWO, 1'b0);
        4'hC:                      r = mk(`CTIM_LEN_TWO, `CTIM_CYC_TWO, 1'b0);
        4'hE, 4'hF:                r = mk(`CTIM_LEN_ONE, `CTIM_CYC_EXT_DATA, 1'b0);
        default:                   r = mk(`CTIM_LEN_TWO, `CTIM_CYC_TWO, 1'b1);
      endcase
    end else if (lo == 4'h3) begin
      case (hi)
        4'h0, 4'h1, 4'h2, 4'h3:    r = mk(`CTIM_LEN_ONE, `CTIM_CYC_ONE, 1'b0);
        4'h4, 4'h5, 4'h6:          r = mk(`CTIM_LEN_THREE, `CTIM_CYC_THREE, 1'b0);
        4'h7, 4'hB, 4'hD:          r = mk(`CTIM_LEN_ONE, `CTIM_CYC_ONE, 1'b1);
        4'h8:                      r = mk(`CTIM_LEN_ONE, `CTIM_CYC_CODE_PC, 1'b0);
        4'h9: begin
          r         = mk(`CTIM_LEN_ONE, `CTIM_CYC_CODE_DP_MIN, 1'b0);
          r.code_dp = 1'b1;
        end
        4'hA, 4'hC:                r = mk(`CTIM_LEN_ONE, `CTIM_CYC_ONE, 1'b0);
        4'hE, 4'hF:                r = mk(`CTIM_LEN_ONE, `CTIM_CYC_EXT_DATA, 1'b0);
        default:                   r = mk(`CTIM_LEN_TWO, `CTIM_CYC_TWO, 1'b1);
      endcase
    end else if (lo == 4'h4) begin
      case (hi)
        4'h0, 4'h1, 4'hC, 4'hD,
        4'hE:                      r = mk(`CTIM_LEN_ONE, `CTIM_CYC_ONE, 1'b0);
        4'h8:                      r = mk(`CTIM_LEN_ONE, `CTIM_CYC_DIV, 1'b0);
        4'hA:                      r = mk(`CTIM_LEN_ONE, `CTIM_CYC_MUL, 1'b0);
        4'hB:                      r = mk(`CTIM_LEN_THREE, `CTIM_CYC_THREE, 1'b1);
        4'hF:                      r = mk(`CTIM_LEN_ONE, `CTIM_CYC_TWO, 1'b0);
        default: begin
          r     = mk(`CTIM_LEN_TWO, `CTIM_CYC_TWO, 1'b0);
          r.opr = ctim_pkg::CTIM_OPR_IMM;
        end
      endcase
    end else if (lo == 4'h5) begin
      case (hi)
        4'h7, 4'h8:                r = mk(`CTIM_LEN_THREE, `CTIM_CYC_THREE, 1'b0);
        4'hA:                      r = mk(`CTIM_LEN_ONE, `CTIM_CYC_ONE, 1'b0);
        4'hB, 4'hD:                r = mk(`CTIM_LEN_THREE, `CTIM_CYC_THREE, 1'b1);
        default:                   r = mk(`CTIM_LEN_TWO, `CTIM_CYC_TWO, 1'b0);
      endcase
      r.opr = ctim_pkg::CTIM_OPR_DIR;
    end else if (lo[3:1] == 3'b011) begin
      case (hi)
        4'h7, 4'h8, 4'hA:          r = mk(`CTIM_LEN_TWO, `CTIM_CYC_TWO, 1'b0);
        4'hB:                      r = mk(`CTIM_LEN_THREE, `CTIM_CYC_THREE, 1'b1);
        default:                   r = mk(`CTIM_LEN_ONE, `CTIM_CYC_TWO, 1'b0);
      endcase
      r.opr = ctim_pkg::CTIM_OPR_IND;
    end else begin
      case (hi)
        4'h7, 4'h8, 4'hA:          r = mk(`CTIM_LEN_TWO, `CTIM_CYC_TWO, 1'b0);
        4'hB:                      r = mk(`CTIM_LEN_THREE, `CTIM_CYC_THREE, 1'b1);
        4'hD:                      r = mk(`CTIM_LEN_TWO, `CTIM_CYC_TWO, 1'b1);
        default:                   r = mk(`CTIM_LEN_ONE, `CTIM_CYC_ONE, 1'b0);
      endcase
      r.opr = ctim_pkg::CTIM_OPR_REG;
    end
    return r;
  endfunction

  always_comb begin
    dbus.info = lookup(dbus.opcode);
  end

endmodule // ctim_decode

// file: logic/ctim_sequencer.sv
// Instruction fetch and clock-count sequencer with operand address outputs
`include "ctim_regs.svh"

module ctim_sequencer #(
  parameter logic [15:0] RESET_PC = `CTIM_RST_PC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  code_data,
  input  wire logic [1:0]  code_dp_extra,
  input  wire logic [1:0]  bank_sel,
  output logic      [15:0] code_addr,
  output logic             code_rd,
  output logic             insn_done,
  output logic      [15:0] insn_pc,
  output logic      [7:0]  insn_opcode,
  output logic      [7:0]  insn_op1,
  output logic      [7:0]  insn_op2,
  output logic      [1:0]  insn_len,
  output logic      [3:0]  insn_cycles,
  output logic      [2:0]  insn_opr,
  output logic             insn_beyond,
  output logic      [4:0]  wreg_addr,
  output logic      [4:0]  ind_ptr_addr,
  output logic      [7:0]  dir_addr,
  output logic             dir_is_sfr,
  output logic      [7:0]  imm_data,
  output logic      [15:0] data_pointer_const
);

  ctim_dec_if dbus ();

  ctim_decode u_decode (
    .dbus (dbus.dec)
  );

  ctim_pkg::ctim_state_e state_reg;
  ctim_pkg::ctim_state_e state_next;
  logic [15:0]           fetch_reg;
  logic [15:0]           start_reg;
  logic [1:0]            idx_reg;
  logic [3:0]            cnt_reg;
  logic [1:0]            len_reg;
  logic [3:0]            cyc_reg;
  logic [7:0]            opcode_reg;
  logic [7:0]            op1_reg;
  logic [7:0]            op2_reg;
  ctim_pkg::ctim_opr_e   opr_reg;
  logic                  beyond_reg;
  logic [3:0]            cyc_first;
  logic [3:0]            cnt_inc;
  logic [1:0]            idx_inc;
  logic                  take_byte;
  logic                  finish;
  logic [7:0]            fin_opcode;
  logic [7:0]            fin_op1;
  logic [7:0]            fin_op2;
  logic [1:0]            fin_len;
  logic [3:0]            fin_cyc;
  ctim_pkg::ctim_opr_e   fin_opr;
  logic                  fin_beyond;
  logic [15:0]           fin_pc;

  // Extra code-read clocks, clipped so the total never passes the longest time
  function automatic logic [3:0] code_dp_cycles(input logic [1:0] extra);
    logic [3:0] total;
    total = `CTIM_CYC_CODE_DP_MIN + {2'b00, extra};
    if (total > `CTIM_CYC_CODE_DP_MAX) begin
      total = `CTIM_CYC_CODE_DP_MAX;
    end
    return total;
  endfunction

  // Register-file address of working register n within a bank
  function automatic logic [4:0] bank_reg(input logic [1:0] bank, input logic [2:0] n);
    return {bank, n};
  endfunction

  assign dbus.opcode = code_data;
  assign cnt_inc     = cnt_reg + `CTIM_CYC_ONE;
  assign idx_inc     = idx_reg + `CTIM_LEN_ONE;

  // Total clocks for the opcode on the bus this cycle
  always_comb begin
    if (dbus.info.code_dp) begin
      cyc_first = code_dp_cycles(code_dp_extra);
    end else begin
      cyc_first = dbus.info.cyc;
    end
  end

  // Next state and the end-of-instruction decision
  always_comb begin
    state_next = state_reg;
    take_byte  = 1'b0;
    finish     = 1'b0;
    case (state_reg)
      ctim_pkg::CTIM_ST_OPCODE: begin
        take_byte = 1'b1;
        if (cyc_first == `CTIM_CYC_ONE) begin
          finish = 1'b1;
        end else if (dbus.info.len != `CTIM_LEN_ONE) begin
          state_next = ctim_pkg::CTIM_ST_OPERAND;
        end else begin
          state_next = ctim_pkg::CTIM_ST_STALL;
        end
      end
      ctim_pkg::CTIM_ST_OPERAND: begin
        take_byte = 1'b1;
        if (cnt_inc == cyc_reg) begin
          finish     = 1'b1;
          state_next = ctim_pkg::CTIM_ST_OPCODE;
        end else if (idx_inc == len_reg) begin
          state_next = ctim_pkg::CTIM_ST_STALL;
        end
      end
      ctim_pkg::CTIM_ST_STALL: begin
        if (cnt_inc == cyc_reg) begin
          finish     = 1'b1;
          state_next = ctim_pkg::CTIM_ST_OPCODE;
        end
      end
      default: begin
        state_next = ctim_pkg::CTIM_ST_OPCODE;
      end
    endcase
  end

  // Values published when an instruction ends; the last operand byte is still on the bus
  always_comb begin
    fin_opcode = opcode_reg;
    fin_op1    = op1_reg;
    fin_op2    = op2_reg;
    fin_len    = len_reg;
    fin_cyc    = cyc_reg;
    fin_opr    = opr_reg;
    fin_beyond = beyond_reg;
    fin_pc     = start_reg;
    if (state_reg == ctim_pkg::CTIM_ST_OPCODE) begin
      fin_opcode = code_data;
      fin_op1    = `CTIM_RST_BYTE;
      fin_op2    = `CTIM_RST_BYTE;
      fin_len    = dbus.info.len;
      fin_cyc    = cyc_first;
      fin_opr    = dbus.info.opr;
      fin_beyond = dbus.info.beyond;
      fin_pc     = fetch_reg;
    end else if (state_reg == ctim_pkg::CTIM_ST_OPERAND) begin
      if (idx_reg == `CTIM_LEN_ONE) begin
        fin_op1 = code_data;
      end else begin
        fin_op2 = code_data;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= ctim_pkg::CTIM_ST_OPCODE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Fetch address moves only when a byte is consumed, so it ends at start plus length
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fetch_reg <= RESET_PC;
    end else if (take_byte) begin
      fetch_reg <= fetch_reg + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      code_addr <= RESET_PC;
      code_rd   <= 1'b0;
    end else begin
      code_addr <= take_byte ? fetch_reg + 16'h0001 : fetch_reg;
      code_rd   <= (state_next != ctim_pkg::CTIM_ST_STALL);
    end
  end

  // Per-instruction bookkeeping latched on the opcode cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      start_reg  <= RESET_PC;
      len_reg    <= `CTIM_LEN_ONE;
      cyc_reg    <= `CTIM_CYC_ONE;
      opcode_reg <= `CTIM_RST_BYTE;
      opr_reg    <= ctim_pkg::CTIM_OPR_NONE;
      beyond_reg <= 1'b0;
    end else if (state_reg == ctim_pkg::CTIM_ST_OPCODE) begin
      start_reg  <= fetch_reg;
      len_reg    <= dbus.info.len;
      cyc_reg    <= cyc_first;
      opcode_reg <= code_data;
      opr_reg    <= dbus.info.opr;
      beyond_reg <= dbus.info.beyond;
    end
  end

  // Clock and byte counters, restarted by every opcode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= `CTIM_CYC_ONE;
      idx_reg <= `CTIM_LEN_ONE;
    end else if (state_reg == ctim_pkg::CTIM_ST_OPCODE) begin
      cnt_reg <= `CTIM_CYC_ONE;
      idx_reg <= `CTIM_LEN_ONE;
    end else begin
      cnt_reg <= cnt_inc;
      if (take_byte) begin
        idx_reg <= idx_inc;
      end
    end
  end

  // Operand bytes in program order
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      op1_reg <= `CTIM_RST_BYTE;
      op2_reg <= `CTIM_RST_BYTE;
    end else if (state_reg == ctim_pkg::CTIM_ST_OPCODE) begin
      op1_reg <= `CTIM_RST_BYTE;
      op2_reg <= `CTIM_RST_BYTE;
    end else if (state_reg == ctim_pkg::CTIM_ST_OPERAND) begin
      if (idx_reg == `CTIM_LEN_ONE) begin
        op1_reg <= code_data;
      end else begin
        op2_reg <= code_data;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      insn_done <= 1'b0;
    end else begin
      insn_done <= finish;
    end
  end

  // Decoded instruction, held stable until the next one ends
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      insn_pc     <= RESET_PC;
      insn_opcode <= `CTIM_RST_BYTE;
      insn_op1    <= `CTIM_RST_BYTE;
      insn_op2    <= `CTIM_RST_BYTE;
      insn_len    <= `CTIM_LEN_ONE;
      insn_cycles <= `CTIM_CYC_ONE;
      insn_opr    <= ctim_pkg::CTIM_OPR_NONE;
      insn_beyond <= 1'b0;
    end else if (finish) begin
      insn_pc     <= fin_pc;
      insn_opcode <= fin_opcode;
      insn_op1    <= fin_op1;
      insn_op2    <= fin_op2;
      insn_len    <= fin_len;
      insn_cycles <= fin_cyc;
      insn_opr    <= fin_opr;
      insn_beyond <= fin_beyond;
    end
  end

  // Operand addresses; bank is sampled at the end so a bank switch applies to the next one
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wreg_addr    <= 5'h00;
      ind_ptr_addr <= 5'h00;
    end else if (finish) begin
      wreg_addr    <= bank_reg(bank_sel, fin_opcode[2:0]);
      ind_ptr_addr <= bank_reg(bank_sel, {2'b00, fin_opcode[`CTIM_PTR_SEL_BIT]});
    end
  end

  // First operand byte doubles as direct address; immediate is the second byte in three-byte forms, else the first
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dir_addr   <= `CTIM_RST_BYTE;
      dir_is_sfr <= 1'b0;
      imm_data   <= `CTIM_RST_BYTE;
      data_pointer_const <= 16'h0000;
    end else if (finish) begin
      dir_addr   <= fin_op1;
      dir_is_sfr <= fin_op1[`CTIM_DIR_SFR_BIT];
      imm_data   <= (fin_len == `CTIM_LEN_THREE) ? fin_op2 : fin_op1;
      data_pointer_const <= {fin_op1, fin_op2};
    end
  end

endmodule // ctim_sequencer

// file: test/ctim_seq_assertions.sv
// Port-level checks for the instruction timing sequencer
module ctim_seq_assertions #(
  parameter logic [15:0] RESET_PC = 16'h0000
) (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [15:0] code_addr,
  input wire logic        code_rd,
  input wire logic        insn_done,
  input wire logic [15:0] insn_pc,
  input wire logic [7:0]  insn_opcode,
  input wire logic [7:0]  insn_op1,
  input wire logic [7:0]  insn_op2,
  input wire logic [1:0]  insn_len,
  input wire logic [3:0]  insn_cycles,
  input wire logic [4:0]  wreg_addr,
  input wire logic [4:0]  ind_ptr_addr,
  input wire logic [7:0]  dir_addr,
  input wire logic        dir_is_sfr,
  input wire logic [7:0]  imm_data,
  input wire logic [15:0] data_pointer_const
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [3:0]  gap_cnt;
  logic [15:0] pc_next;
  // Clocks since the last finished instruction
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gap_cnt <= 4'h0;
    end else begin
      gap_cnt <= insn_done ? 4'h1 : gap_cnt + 4'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pc_next <= RESET_PC;
    end else if (insn_done) begin
      pc_next <= insn_pc + 16'(insn_len);
    end
  end
  AST_GAP_EQ_CYCLES: assert property (insn_done |-> gap_cnt == insn_cycles)
    else $error("instruction time differs from reported clocks");
  AST_PC_ADVANCE: assert property (insn_done |-> insn_pc == pc_next)
    else $error("opcode address not advanced by length");
  AST_LEN_RANGE: assert property (insn_done |-> insn_len inside {2'h1, 2'h2, 2'h3})
    else $error("length out of range");
  AST_WREG_SEL: assert property (insn_done |-> wreg_addr[2:0] == insn_opcode[2:0])
    else $error("working register select wrong");
  AST_IND_PTR: assert property (insn_done |-> ind_ptr_addr[2:0] == {2'b00, insn_opcode[0]})
    else $error("indirect pointer not register 0 or 1");
  AST_DIR_SPACE: assert property (insn_done |-> dir_addr == insn_op1 && dir_is_sfr == insn_op1[7])
    else $error("direct address space wrong");
  AST_IMM_BYTE: assert property (insn_done |-> imm_data == (insn_len == 2'h3 ? insn_op2 : insn_op1))
    else $error("immediate byte wrong");
  AST_DATA_POINTER_CONST: assert property (insn_done |-> data_pointer_const == {insn_op1, insn_op2})
    else $error("pointer constant byte order wrong");
  AST_FETCH_STEP: assert property (code_rd && $past(code_rd) |-> code_addr == $past(code_addr) + 16'h1)
    else $error("fetch address skipped or repeated");
  AST_RESET_STATE: assert property (@(posedge ref_clk) disable iff (1'b0)
    rst |=> code_addr == RESET_PC && !code_rd && !insn_done)
    else $error("reset state wrong");
endmodule // ctim_seq_assertions

bind ctim_sequencer ctim_seq_assertions #(.RESET_PC(RESET_PC)) i_chk (
  .ref_clk(ref_clk), .rst(rst), .code_addr(code_addr), .code_rd(code_rd), .insn_done(insn_done),
  .insn_pc(insn_pc), .insn_opcode(insn_opcode), .insn_op1(insn_op1), .insn_op2(insn_op2),
  .insn_len(insn_len), .insn_cycles(insn_cycles), .wreg_addr(wreg_addr), .ind_ptr_addr(ind_ptr_addr),
  .dir_addr(dir_addr), .dir_is_sfr(dir_is_sfr), .imm_data(imm_data), .data_pointer_const(data_pointer_const)
);

// file: test/ctim_code_mem.sv
// Program memory model with a same-clock read port
module ctim_code_mem (
  input  wire logic        ref_clk,
  input  wire logic        clr,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic [15:0] code_addr,
  output logic      [7:0]  code_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  // Cleared bytes read as no-operation opcodes
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      for (int i = 0; i < 256; i++) mem[i] <= 8'h00;
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  // Low byte only; test programs stay below 256 bytes
  assign code_data = mem[code_addr[7:0]];
endmodule // ctim_code_mem

// file: test/cpu_instruction_timing_tb.sv
// Self-checking bench for the instruction timing sequencer
module cpu_instruction_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk;
  logic        rst;
  logic        clr;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  code_data;
  logic [1:0]  code_dp_extra;
  logic [1:0]  bank_sel;
  logic [15:0] code_addr;
  logic        code_rd;
  logic        insn_done;
  logic [15:0] insn_pc;
  logic [7:0]  insn_opcode;
  logic [7:0]  insn_op1;
  logic [7:0]  insn_op2;
  logic [1:0]  insn_len;
  logic [3:0]  insn_cycles;
  logic [2:0]  insn_opr;
  logic        insn_beyond;
  logic [4:0]  wreg_addr;
  logic [4:0]  ind_ptr_addr;
  logic [7:0]  dir_addr;
  logic        dir_is_sfr;
  logic [7:0]  imm_data;
  logic [15:0] data_pointer_const;
  logic [31:0] q [$];
  logic [7:0]  fill;
  int          err_total;
  int          checks;

  ctim_sequencer i_dut (
    .ref_clk(ref_clk), .rst(rst), .code_data(code_data), .code_dp_extra(code_dp_extra),
    .bank_sel(bank_sel), .code_addr(code_addr), .code_rd(code_rd), .insn_done(insn_done),
    .insn_pc(insn_pc), .insn_opcode(insn_opcode), .insn_op1(insn_op1), .insn_op2(insn_op2),
    .insn_len(insn_len), .insn_cycles(insn_cycles), .insn_opr(insn_opr), .insn_beyond(insn_beyond),
    .wreg_addr(wreg_addr), .ind_ptr_addr(ind_ptr_addr), .dir_addr(dir_addr),
    .dir_is_sfr(dir_is_sfr), .imm_data(imm_data), .data_pointer_const(data_pointer_const)
  );
  ctim_code_mem i_mem (
    .ref_clk(ref_clk), .clr(clr), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .code_addr(code_addr), .code_data(code_data)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Loads happen under reset so the sequencer never fetches half a program
  task automatic begin_prog(input logic [1:0] bank, input logic [1:0] extra);
    rst = 1'b1;
    clr = 1'b1;
    bank_sel = bank;
    code_dp_extra = extra;
    @(negedge ref_clk);
    clr = 1'b0;
    repeat (2) @(negedge ref_clk);
    fill = 8'h00;
    q.delete();
  endtask

  task automatic poke(input logic [7:0] a, input logic [7:0] d);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge ref_clk);
  endtask

  task automatic add(input logic [7:0] op, input logic [1:0] len, input logic [3:0] cyc,
                     input logic [7:0] b1, input logic [7:0] b2);
    q.push_back({op, len > 2'h1 ? b1 : 8'h00, len > 2'h2 ? b2 : 8'h00, 2'b00, len, cyc});
    poke(fill, op);
    if (len > 2'h1) poke(fill + 8'h01, b1);
    if (len > 2'h2) poke(fill + 8'h02, b2);
    fill = fill + 8'(len);
  endtask

  task automatic run();
    logic [31:0] e;
    logic [15:0] pc;
    logic [2:0]  opr;
    int          n;
    pc = 16'h0000;
    wr_en = 1'b0;
    rst = 1'b0;
    foreach (q[i]) begin
      e = q[i];
      n = 0;
      // Operand class follows the opcode's low nibble, and for low nibble 4 its length
      opr = 3'h0;
      if (e[27:24] == 4'h4 && e[5:4] == 2'h2) begin
        opr = 3'h4;
      end else if (e[27:24] == 4'h5) begin
        opr = 3'h3;
      end else if (e[27:25] == 3'b011) begin
        opr = 3'h2;
      end else if (e[27]) begin
        opr = 3'h1;
      end
      do begin
        @(negedge ref_clk);
        n++;
      end while (insn_done !== 1'b1 && n < 20);
      check(16'(n), 16'(e[3:0]), "clocks taken");
      check(16'(insn_cycles), 16'(e[3:0]), "reported clocks");
      check(16'(insn_opcode), 16'(e[31:24]), "opcode");
      check(16'(insn_len), 16'(e[5:4]), "length");
      check(insn_pc, pc, "opcode address");
      check({insn_op1, insn_op2}, e[23:8], "operand bytes");
      check(16'(wreg_addr), 16'({bank_sel, e[26:24]}), "register select");
      check(16'(ind_ptr_addr), 16'({bank_sel, 2'b00, e[24]}), "pointer select");
      check(16'(dir_is_sfr), 16'(e[23]), "direct space");
      check(16'(insn_beyond), 16'(e[6]), "outside table");
      check(16'(insn_opr), 16'(opr), "operand class");
      check(16'(dir_addr), 16'(e[23:16]), "direct address");
      check(16'(imm_data), 16'(e[5:4] == 2'h3 ? e[15:8] : e[23:16]), "immediate byte");
      check(data_pointer_const, e[23:8], "pointer constant");
      pc = pc + 16'(e[5:4]);
    end
  endtask

  task automatic sc_arith();
    logic [7:0] fam [3];
    fam = '{8'h20, 8'h30, 8'h90};
    begin_prog(2'b01, 2'b00);
    for (int k = 0; k < 3; k++) begin
      add(fam[k] + 8'h08 + 8'(k * 3), 2'h1, 4'h1, 8'h00, 8'h00);
      add(fam[k] + 8'h05, 2'h2, 4'h2, 8'h7F + 8'(k), 8'h00);
      add(fam[k] + 8'h06 + 8'(k & 1), 2'h1, 4'h2, 8'h00, 8'h00);
      add(fam[k] + 8'h04, 2'h2, 4'h2, 8'h5A, 8'h00);
    end
    add(8'hA3, 2'h1, 4'h1, 8'h00, 8'h00);
    add(8'h05, 2'h2, 4'h2, 8'hFF, 8'h00);
    add(8'h17, 2'h1, 4'h2, 8'h00, 8'h00);
    run();
  endtask

  task automatic sc_logic();
    logic [7:0] rot [4];
    rot = '{8'h23, 8'h33, 8'h03, 8'h13};
    begin_prog(2'b10, 2'b00);
    add(8'h53, 2'h3, 4'h3, 8'h80, 8'hC3);
    add(8'h43, 2'h3, 4'h3, 8'h7F, 8'h3C);
    add(8'h63, 2'h3, 4'h3, 8'hE0, 8'h01);
    add(8'h52, 2'h2, 4'h2, 8'h22, 8'h00);
    add(8'h66, 2'h1, 4'h2, 8'h00, 8'h00);
    add(8'h67, 2'h1, 4'h2, 8'h00, 8'h00);
    foreach (rot[i]) add(rot[i], 2'h1, 4'h1, 8'h00, 8'h00);
    // Branch outside the table reports its length as its time
    add(8'h80, 2'h2, 4'h2, 8'h00, 8'h00);
    q[q.size() - 1][6] = 1'b1;
    add(8'hA5, 2'h1, 4'h1, 8'h00, 8'h00);
    run();
  endtask

  task automatic sc_move();
    begin_prog(2'b11, 2'b00);
    add(8'h85, 2'h3, 4'h3, 8'h90, 8'h10);
    add(8'h77, 2'h2, 4'h2, 8'hA6, 8'h00);
    add(8'h90, 2'h3, 4'h3, 8'h12, 8'h34);
    add(8'hC0, 2'h2, 4'h2, 8'hF0, 8'h00);
    add(8'hD0, 2'h2, 4'h2, 8'h08, 8'h00);
    add(8'hCD, 2'h1, 4'h1, 8'h00, 8'h00);
    add(8'hD7, 2'h1, 4'h2, 8'h00, 8'h00);
    add(8'h86, 2'h2, 4'h2, 8'h81, 8'h00);
    add(8'hF6, 2'h1, 4'h2, 8'h00, 8'h00);
    run();
  endtask

  // Every extra-clock setting of the pointer code read, with external moves between
  task automatic sc_code();
    logic [7:0] ext [6];
    ext = '{8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3};
    for (int x = 0; x < 4; x++) begin
      begin_prog(2'(x), 2'(x));
      add(8'h93, 2'h1, 4'h4 + 4'(x), 8'h00, 8'h00);
      add(8'h83, 2'h1, 4'h3, 8'h00, 8'h00);
      foreach (ext[i]) add(ext[i], 2'h1, 4'h3, 8'h00, 8'h00);
      add(8'h93, 2'h1, 4'h4 + 4'(x), 8'h00, 8'h00);
      run();
    end
  endtask

  initial begin
    #100us;
    err_total++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    clr = 1'b0;
    wr_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    code_dp_extra = 2'b00;
    bank_sel = 2'b00;
    err_total = 0;
    checks = 0;
    repeat (3) @(negedge ref_clk);
    sc_arith();
    sc_logic();
    sc_move();
    sc_code();
    complete_run();
  end
endmodule // cpu_instruction_timing_tb
